// ===== inc/mc_regs_map.svh
`ifndef MC_REGS_MAP_SVH
`define MC_REGS_MAP_SVH

// Register addresses (byte-wide locations)
`define ADR_PREV_CAPTURE   4'h0
`define ADR_CURR_CAPTURE   4'h1
`define ADR_NEXT_COMP      4'h2
`define ADR_DEMAG_VALUE    4'h3
`define ADR_DELAY_WEIGHT   4'h4
`define ADR_PRESCALE_SMP   4'h5
`define ADR_IRQ_MASK       4'h6
`define ADR_IRQ_FLAGS      4'h7
`define ADR_MAIN_CONTROL   4'h8
`define ADR_CONTROL_B      4'h9

// Reset value of every register
`define REG_RESET          8'h00

// Flag / mask bit positions
`define BIT_PWM_UPD        7
`define BIT_SPEED_ERR      6
`define BIT_RATIO_INC      6
`define BIT_RATIO_DEC      5
`define BIT_RATIO_MASK     5
`define BIT_CURLIMIT       4
`define BIT_ESTOP          3
`define BIT_ZCROSS         2
`define BIT_DEMAG_END      1
`define BIT_COMMUTATION    0

// Main control bits
`define BIT_OUTPUT_EN      7
`define BIT_CLK_EN         6
`define BIT_SENSOR_MODE    5
`define BIT_VOLT_CURR      3
`define BIT_AUTOSWITCH     2
`define BIT_MULT_SRC       0

// Control B bits
`define BIT_HW_DEMAG       5
`define BIT_SIM_DEMAG      4

// Special status write value forcing an update event
`define RESYNC_VALUE       8'hFF

// Speed sensor select value meaning "no speed sensor"
`define SPEED_SENSOR_OFF   2'h0

// Nibble bounds of the prescaler field
`define PRESC_MAX          4'hF
`define PRESC_MIN          4'h0

`endif

// ===== inc/mc_regs_pkg.sv
package mc_regs_pkg;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_type;

  typedef struct packed {
    logic zcross;
    logic commutation;
    logic hw_demag;
    logic sim_demag_end;
    logic estop;
    logic curlimit;
    logic pwm_preload_done;
    logic speed_capture;
  } mc_events_type;

  typedef enum logic [1:0] {
    MODE_SWITCHED,
    MODE_AUTOSWITCHED,
    MODE_SPEED
  } mc_mode_type;

endpackage

// ===== verilog/mc_capture_irq_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "mc_regs_map.svh"
// Summary of operation
// - Captures hold previous/latest zero-crossing, or step-timer low/high bytes in speed mode.
// - Speed mode: reading current capture blocks captures until previous capture is read.
// - Next-commutation compare register holds the 8-bit next commutation value.
// - Demag register is simulated-demag compare and takes hardware demag capture.
// - Speed mode: demag value matching step timer raises speed error.
// - Autoswitched: each zero-crossing loads compare with weight times capture over 256.
// - Upper prescaler nibble selects current-mode sampling ratio.
// - Lower nibble is step prescaler; ratio-increase increments, ratio-decrease decrements.
// - Mask bits 7..0 enable PWM update down to commutation interrupts.
// - Current limitation interrupt only in voltage mode on current limit reached.
// - Demag-end interrupt needs mask bit and hardware or simulated demag enabled.
// - PWM update flag set when compare preloads are copied to active registers.
// - Ratio bits are pending flags in autoswitched and speed sensor modes.
// - Switched mode: ratio bits adjust prescaler and shift timers at next commutation.
// - Writing FFh to status resets PWM counter, transfers preloads, sets update flag.
// - Autoswitched: flags set by hardware only; writing 1 has no effect.
// - Output enable low puts phase outputs to reset state; high drives them.
// - Outputs off, sensorless, PWM-rate sampling: keep bit decides zero-cross sampling.
// - Clock enable low stops delay manager, sampling and PWM clocks; no events.
// - Register writes work while peripheral clocks are disabled.
// - Multiplier source picks previous capture at 0, current capture at 1.
// - Setting clock enable transfers preloads; clearing holds PWM counter at zero.
// - Autoswitch select chooses switched mode at 0, autoswitched at 1.
module mc_capture_irq_regs (
  // Clock and reset
  input  wire logic                      CLK_SYS_I,
  input  wire logic                      RSTN_I,
  // Register port
  input  wire mc_regs_pkg::bus_req_type  BUS_I,
  output logic                     [7:0] RDATA_O,
  // Motor core events and data
  input  wire mc_regs_pkg::mc_events_type EVT_I,
  input  wire logic                [7:0] ZCAP_VALUE_I,
  input  wire logic                [7:0] DEMAG_CAP_I,
  input  wire logic               [15:0] STEP_TIMER_I,
  input  wire logic                [1:0] SPEED_SENSOR_SEL_I,
  input  wire logic                      PWM_RATE_SAMPLING_I,
  input  wire logic                      Z_SAMPLING_KEEP_I,
  // Controls toward motor core
  output logic                           PERIPH_CLK_EN_O,
  output logic                           PWM_CNT_RESET_O,
  output logic                           PRELOAD_XFER_O,
  output logic                           PHASE_DRIVE_EN_O,
  output logic                           Z_SAMPLING_RUN_O,
  output logic                           TIMER_SHIFT_RIGHT_O,
  output logic                           TIMER_SHIFT_LEFT_O,
  output logic                     [3:0] CURR_MODE_SMP_RATIO_O,
  output logic                     [3:0] COMMUT_PRESCALER_O,
  output logic                     [7:0] NEXT_COMMUTATION_O,
  output logic                     [7:0] IRQ_LINES_O
);
  import mc_regs_pkg::*;

  // ********************************************************************
  // Registers and decode
  // ********************************************************************
  logic [7:0]  prev_capture_r;
  logic [7:0]  curr_capture_r;
  logic [7:0]  next_commutation_compare_r;
  logic [7:0]  demag_value_r;
  logic [7:0]  delay_weight_r;
  logic [7:0]  prescale_and_sampling_r;
  logic [7:0]  irq_enable_mask_r;
  logic [7:0]  irq_pending_flags_r;
  logic [7:0]  main_control_r;
  logic [7:0]  control_b_r;
  logic        speed_capture_lock_r;
  logic        clk_en_d_r;
  logic [7:0]  flags_nxt;
  logic [7:0]  set_vec;
  logic [15:0] product;
  logic [7:0]  mult_src;
  logic        clk_en;
  logic        speed_mode;
  mc_mode_type mode;

  function automatic logic wr_hit(input bus_req_type b, input logic [3:0] a);
    wr_hit = b.wr && (b.addr == a);
  endfunction

  function automatic logic rd_hit(input bus_req_type b, input logic [3:0] a);
    rd_hit = b.rd && (b.addr == a);
  endfunction

  assign clk_en     = main_control_r[`BIT_CLK_EN];
  assign speed_mode = (SPEED_SENSOR_SEL_I != `SPEED_SENSOR_OFF);

  assign mode = speed_mode ? MODE_SPEED
              : main_control_r[`BIT_AUTOSWITCH] ? MODE_AUTOSWITCHED
                                                : MODE_SWITCHED;

  // Multiplicand choice for the commutation delay
  assign mult_src = main_control_r[`BIT_MULT_SRC] ? curr_capture_r
                                                  : prev_capture_r;
  assign product  = delay_weight_r * mult_src;

  // ********************************************************************
  // Capture registers
  // ********************************************************************
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      prev_capture_r <= `REG_RESET;
      curr_capture_r <= `REG_RESET;
    end else if (clk_en && mode == MODE_SPEED && EVT_I.speed_capture
                 && !speed_capture_lock_r) begin
      prev_capture_r <= STEP_TIMER_I[7:0];
      curr_capture_r <= STEP_TIMER_I[15:8];
    end else if (clk_en && mode != MODE_SPEED && EVT_I.zcross) begin
      prev_capture_r <= curr_capture_r;
      curr_capture_r <= ZCAP_VALUE_I;
    end else begin
      if (wr_hit(BUS_I, `ADR_PREV_CAPTURE)) begin
        prev_capture_r <= BUS_I.wdata;
      end
      if (wr_hit(BUS_I, `ADR_CURR_CAPTURE)) begin
        curr_capture_r <= BUS_I.wdata;
      end
    end
  end

  // High-byte read locks the pair so software sees a coherent 16-bit value
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      speed_capture_lock_r <= 1'b0;
    end else if (mode != MODE_SPEED) begin
      speed_capture_lock_r <= 1'b0;
    end else if (rd_hit(BUS_I, `ADR_PREV_CAPTURE)) begin
      speed_capture_lock_r <= 1'b0;
    end else if (rd_hit(BUS_I, `ADR_CURR_CAPTURE)) begin
      speed_capture_lock_r <= 1'b1;
    end
  end

  // ********************************************************************
  // Compare and demag registers
  // ********************************************************************
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      next_commutation_compare_r <= `REG_RESET;
    end else if (clk_en && mode == MODE_AUTOSWITCHED && EVT_I.zcross) begin
      next_commutation_compare_r <= product[15:8];
    end else if (wr_hit(BUS_I, `ADR_NEXT_COMP)) begin
      next_commutation_compare_r <= BUS_I.wdata;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      demag_value_r <= `REG_RESET;
    end else if (clk_en && mode != MODE_SPEED && EVT_I.hw_demag
                 && control_b_r[`BIT_HW_DEMAG]) begin
      demag_value_r <= DEMAG_CAP_I;
    end else if (wr_hit(BUS_I, `ADR_DEMAG_VALUE)) begin
      demag_value_r <= BUS_I.wdata;
    end
  end

  // ********************************************************************
  // Prescaler and sampling
  // ********************************************************************
  logic ratio_inc_evt;
  logic ratio_dec_evt;

  // Switched mode: pending ratio bits act at the next commutation
  assign ratio_inc_evt = clk_en && mode == MODE_SWITCHED && EVT_I.commutation
                         && irq_pending_flags_r[`BIT_RATIO_INC]
                         && !irq_pending_flags_r[`BIT_RATIO_DEC];
  assign ratio_dec_evt = clk_en && mode == MODE_SWITCHED && EVT_I.commutation
                         && irq_pending_flags_r[`BIT_RATIO_DEC]
                         && !irq_pending_flags_r[`BIT_RATIO_INC];
  // Both bits set in switched mode act on neither; set them one at a time

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      prescale_and_sampling_r <= `REG_RESET;
    end else if (wr_hit(BUS_I, `ADR_PRESCALE_SMP)) begin
      prescale_and_sampling_r <= BUS_I.wdata;
    end else if (ratio_inc_evt
                 && prescale_and_sampling_r[3:0] != `PRESC_MAX) begin
      prescale_and_sampling_r[3:0] <= prescale_and_sampling_r[3:0] + 4'h1;
    end else if (ratio_dec_evt
                 && prescale_and_sampling_r[3:0] != `PRESC_MIN) begin
      prescale_and_sampling_r[3:0] <= prescale_and_sampling_r[3:0] - 4'h1;
    end
  end

  // ********************************************************************
  // Mask, control registers
  // ********************************************************************
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      delay_weight_r    <= `REG_RESET;
      irq_enable_mask_r <= `REG_RESET;
      main_control_r    <= `REG_RESET;
      control_b_r       <= `REG_RESET;
    end else begin
      if (wr_hit(BUS_I, `ADR_DELAY_WEIGHT)) begin
        delay_weight_r <= BUS_I.wdata;
      end
      if (wr_hit(BUS_I, `ADR_IRQ_MASK)) begin
        irq_enable_mask_r <= BUS_I.wdata;
      end
      if (wr_hit(BUS_I, `ADR_MAIN_CONTROL)) begin
        main_control_r <= BUS_I.wdata;
      end
      if (wr_hit(BUS_I, `ADR_CONTROL_B)) begin
        control_b_r <= BUS_I.wdata;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      clk_en_d_r <= 1'b0;
    end else begin
      clk_en_d_r <= clk_en;
    end
  end

  // ********************************************************************
  // Status flags
  // ********************************************************************
  logic resync_wr;
  logic clk_en_rise;

  assign resync_wr   = wr_hit(BUS_I, `ADR_IRQ_FLAGS)
                       && BUS_I.wdata == `RESYNC_VALUE;
  assign clk_en_rise = clk_en && !clk_en_d_r;

  always_comb begin
    set_vec = 8'h00;
    if (clk_en) begin
      set_vec[`BIT_PWM_UPD]     = EVT_I.pwm_preload_done;
      set_vec[`BIT_CURLIMIT]    = EVT_I.curlimit
                                  && !main_control_r[`BIT_VOLT_CURR];
      set_vec[`BIT_ESTOP]       = EVT_I.estop;
      set_vec[`BIT_ZCROSS]      = EVT_I.zcross;
      set_vec[`BIT_DEMAG_END]   = (EVT_I.hw_demag && control_b_r[`BIT_HW_DEMAG])
                                  || (EVT_I.sim_demag_end
                                      && control_b_r[`BIT_SIM_DEMAG]);
      set_vec[`BIT_COMMUTATION] = EVT_I.commutation;
    end
    if (resync_wr || clk_en_rise) begin
      set_vec[`BIT_PWM_UPD] = 1'b1;
    end
  end

  always_comb begin
    flags_nxt = irq_pending_flags_r;
    if (resync_wr) begin
      flags_nxt = irq_pending_flags_r; // Only the update flag reacts
    end else if (wr_hit(BUS_I, `ADR_IRQ_FLAGS)) begin
      if (mode == MODE_SWITCHED) begin
        // Ratio bits are software commands here; other flags clear-only
        flags_nxt = irq_pending_flags_r & BUS_I.wdata;
        flags_nxt[`BIT_RATIO_INC] = BUS_I.wdata[`BIT_RATIO_INC];
        flags_nxt[`BIT_RATIO_DEC] = BUS_I.wdata[`BIT_RATIO_DEC];
      end else begin
        // Ratio bits are plain flags here, with no hardware source yet
        flags_nxt = irq_pending_flags_r & BUS_I.wdata;
      end
    end else if (ratio_inc_evt || ratio_dec_evt) begin
      flags_nxt[`BIT_RATIO_INC] = 1'b0;
      flags_nxt[`BIT_RATIO_DEC] = 1'b0;
    end
    flags_nxt = flags_nxt | set_vec; // Set wins over clear
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      irq_pending_flags_r <= `REG_RESET;
    end else begin
      irq_pending_flags_r <= flags_nxt;
    end
  end

  // ********************************************************************
  // Speed error and interrupt lines
  // ********************************************************************
  logic speed_err_r;

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      speed_err_r <= 1'b0;
    end else begin
      speed_err_r <= clk_en && mode == MODE_SPEED
                     && STEP_TIMER_I[15:8] == demag_value_r;
    end
  end

  logic [7:0] irq_src;
  always_comb begin
    irq_src = irq_pending_flags_r;
    irq_src[`BIT_SPEED_ERR] = speed_err_r;
    irq_src[`BIT_RATIO_MASK] = irq_pending_flags_r[`BIT_RATIO_INC]
                               | irq_pending_flags_r[`BIT_RATIO_DEC];
    if (mode == MODE_SWITCHED) begin
      irq_src[`BIT_RATIO_MASK] = 1'b0;
    end
    irq_src[`BIT_DEMAG_END] = irq_pending_flags_r[`BIT_DEMAG_END]
                              && (control_b_r[`BIT_HW_DEMAG]
                                  || control_b_r[`BIT_SIM_DEMAG]);
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      IRQ_LINES_O <= `REG_RESET;
    end else begin
      IRQ_LINES_O <= irq_src & irq_enable_mask_r;
    end
  end

  // ********************************************************************
  // Core controls
  // ********************************************************************
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      PERIPH_CLK_EN_O       <= 1'b0;
      PWM_CNT_RESET_O       <= 1'b1;
      PRELOAD_XFER_O        <= 1'b0;
      PHASE_DRIVE_EN_O      <= 1'b0;
      Z_SAMPLING_RUN_O      <= 1'b0;
      TIMER_SHIFT_RIGHT_O   <= 1'b0;
      TIMER_SHIFT_LEFT_O    <= 1'b0;
      CURR_MODE_SMP_RATIO_O <= 4'h0;
      COMMUT_PRESCALER_O    <= 4'h0;
      NEXT_COMMUTATION_O    <= `REG_RESET;
    end else begin
      PERIPH_CLK_EN_O       <= clk_en;
      PWM_CNT_RESET_O       <= !clk_en || resync_wr;
      PRELOAD_XFER_O        <= resync_wr || clk_en_rise;
      PHASE_DRIVE_EN_O      <= main_control_r[`BIT_OUTPUT_EN];
      Z_SAMPLING_RUN_O      <= clk_en
                               && (main_control_r[`BIT_OUTPUT_EN]
                                   || main_control_r[`BIT_SENSOR_MODE]
                                   || !PWM_RATE_SAMPLING_I
                                   || Z_SAMPLING_KEEP_I);
      TIMER_SHIFT_RIGHT_O   <= ratio_inc_evt;
      TIMER_SHIFT_LEFT_O    <= ratio_dec_evt;
      CURR_MODE_SMP_RATIO_O <= prescale_and_sampling_r[7:4];
      COMMUT_PRESCALER_O    <= prescale_and_sampling_r[3:0];
      NEXT_COMMUTATION_O    <= next_commutation_compare_r;
    end
  end

  // ********************************************************************
  // Read path
  // ********************************************************************
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (BUS_I.addr == `ADR_PREV_CAPTURE) begin
      rd_mux = prev_capture_r;
    end else if (BUS_I.addr == `ADR_CURR_CAPTURE) begin
      rd_mux = curr_capture_r;
    end else if (BUS_I.addr == `ADR_NEXT_COMP) begin
      rd_mux = next_commutation_compare_r;
    end else if (BUS_I.addr == `ADR_DEMAG_VALUE) begin
      rd_mux = demag_value_r;
    end else if (BUS_I.addr == `ADR_DELAY_WEIGHT) begin
      rd_mux = delay_weight_r;
    end else if (BUS_I.addr == `ADR_PRESCALE_SMP) begin
      rd_mux = prescale_and_sampling_r;
    end else if (BUS_I.addr == `ADR_IRQ_MASK) begin
      rd_mux = irq_enable_mask_r;
    end else if (BUS_I.addr == `ADR_IRQ_FLAGS) begin
      rd_mux = irq_pending_flags_r;
    end else if (BUS_I.addr == `ADR_MAIN_CONTROL) begin
      rd_mux = main_control_r;
    end else if (BUS_I.addr == `ADR_CONTROL_B) begin
      rd_mux = control_b_r;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      RDATA_O <= `REG_RESET;
    end else begin
      RDATA_O <= BUS_I.rd ? rd_mux : `REG_RESET;
    end
  end

endmodule
`default_nettype wire

// ===== bench/mc_capture_irq_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module mc_capture_irq_regs_checker (
  // Clock, reset and register port
  input wire logic                     CLK_SYS_I,
  input wire logic                     RSTN_I,
  input wire mc_regs_pkg::bus_req_type BUS_I,
  input wire logic [7:0]               RDATA_O,
  // Events and controls
  input wire mc_regs_pkg::mc_events_type EVT_I,
  input wire logic                     PERIPH_CLK_EN_O,
  input wire logic                     PWM_CNT_RESET_O,
  input wire logic                     PRELOAD_XFER_O,
  input wire logic                     PHASE_DRIVE_EN_O,
  input wire logic                     Z_SAMPLING_RUN_O,
  input wire logic                     TIMER_SHIFT_RIGHT_O,
  input wire logic                     TIMER_SHIFT_LEFT_O,
  input wire logic [7:0]               IRQ_LINES_O
);
  import mc_regs_pkg::*;
  // Mask shadow from bus writes
  logic [7:0] mask_r;
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      mask_r <= 8'h00;
    end else if (BUS_I.wr && BUS_I.addr == 4'h6) begin
      mask_r <= BUS_I.wdata;
    end
  end
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RSTN_I);
  // ****************************************
  // Properties
  // ****************************************
  chk_rdata_idle: assert property (
    !$past(BUS_I.rd) |-> RDATA_O == 8'h00)
    else $error("Read data not zero outside read slot");
  chk_clk_en_bit: assert property (
    $past(BUS_I.wr && BUS_I.addr == 4'h8, 2)
    |-> PERIPH_CLK_EN_O == $past(BUS_I.wdata[6], 2))
    else $error("Clock enable output differs from written bit");
  chk_drive_en_bit: assert property (
    $past(BUS_I.wr && BUS_I.addr == 4'h8, 2)
    |-> PHASE_DRIVE_EN_O == $past(BUS_I.wdata[7], 2))
    else $error("Phase drive enable differs from written bit");
  chk_cnt_held: assert property (
    !PERIPH_CLK_EN_O |-> PWM_CNT_RESET_O)
    else $error("PWM counter not held while clocks off");
  chk_preload_rise: assert property (
    $rose(PERIPH_CLK_EN_O) |-> PRELOAD_XFER_O)
    else $error("No preload transfer on clock enable");
  chk_resync_ffh: assert property (
    PERIPH_CLK_EN_O && BUS_I.wr && BUS_I.addr == 4'h7
    && BUS_I.wdata == 8'hFF |-> ##[1:2] (PRELOAD_XFER_O && PWM_CNT_RESET_O))
    else $error("Resync write did not reset and transfer");
  chk_irq_masked: assert property (
    (IRQ_LINES_O & ~$past(mask_r)) == 8'h00)
    else $error("Interrupt line active while masked");
  chk_zcross_irq: assert property (
    PERIPH_CLK_EN_O && EVT_I.zcross && mask_r[2] && !BUS_I.wr
    |-> ##[1:3] IRQ_LINES_O[2])
    else $error("Zero-crossing interrupt missing");
  chk_shift_excl: assert property (
    !(TIMER_SHIFT_RIGHT_O && TIMER_SHIFT_LEFT_O))
    else $error("Timer shifted both ways at once");
  chk_zsamp_off: assert property (
    !PERIPH_CLK_EN_O |-> !Z_SAMPLING_RUN_O)
    else $error("Zero-cross sampling runs with clocks off");
  cov_preload: cover property (PRELOAD_XFER_O);
  cov_shift_r: cover property (TIMER_SHIFT_RIGHT_O);
  cov_shift_l: cover property (TIMER_SHIFT_LEFT_O);
endmodule
`default_nettype wire

// ===== bench/mc_capture_irq_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mc_capture_irq_regs_tb_top;
  import mc_regs_pkg::*;
  localparam logic [7:0] AUTO_EXP = 8'((16'h003C * 16'h00C8) >> 8);
  logic          clk, rstn, pwm_rate, z_keep, clk_en, cnt_rst;
  logic          xfer, drive_en, z_run, shr, shl;
  bus_req_type   bus;
  mc_events_type evt;
  logic [7:0]    zcap, dcap, rdata, next_comp, irq;
  logic [15:0]   step;
  logic [1:0]    spd_sel;
  logic [3:0]    ratio, presc;
  int            err_count = 0;
  int            comparisons = 0;
  int            xfer_seen, rst_seen, shr_seen, shl_seen, spd_seen;
  mc_capture_irq_regs u_dut (
    .CLK_SYS_I(clk), .RSTN_I(rstn), .BUS_I(bus), .RDATA_O(rdata),
    .EVT_I(evt), .ZCAP_VALUE_I(zcap), .DEMAG_CAP_I(dcap),
    .STEP_TIMER_I(step), .SPEED_SENSOR_SEL_I(spd_sel),
    .PWM_RATE_SAMPLING_I(pwm_rate), .Z_SAMPLING_KEEP_I(z_keep),
    .PERIPH_CLK_EN_O(clk_en), .PWM_CNT_RESET_O(cnt_rst),
    .PRELOAD_XFER_O(xfer), .PHASE_DRIVE_EN_O(drive_en),
    .Z_SAMPLING_RUN_O(z_run), .TIMER_SHIFT_RIGHT_O(shr),
    .TIMER_SHIFT_LEFT_O(shl), .CURR_MODE_SMP_RATIO_O(ratio),
    .COMMUT_PRESCALER_O(presc), .NEXT_COMMUTATION_O(next_comp),
    .IRQ_LINES_O(irq));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Pulses are counted, since their exact cycle is the design's choice
  always @(posedge clk) begin
    if (xfer) xfer_seen++;
    if (cnt_rst && clk_en) rst_seen++;
    if (shr) shr_seen++;
    if (shl) shl_seen++;
    if (irq[6]) spd_seen++;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    chk($sformatf("reg %0h", a), e, rdata);
    @(posedge clk);
  endtask
  task automatic pulse(input logic [7:0] e);
    evt <= mc_events_type'(e);
    @(posedge clk);
    evt <= '0;
    repeat (2) @(posedge clk);
  endtask
  task automatic clr();
    xfer_seen = 0;
    rst_seen = 0;
    shr_seen = 0;
    shl_seen = 0;
    spd_seen = 0;
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_clock_off();
    chk("cnt_rst", 8'h01, {7'h00, cnt_rst});
    for (int a = 0; a < 16; a++) rd_chk(a[3:0], 8'h00);
    for (int a = 2; a < 7; a++) begin
      wr_reg(a[3:0], 8'(8'h11 * a));
      rd_chk(a[3:0], 8'(8'h11 * a));
    end
    chk("ratio", 8'h05, {4'h0, ratio});
    chk("presc", 8'h05, {4'h0, presc});
    chk("next", 8'h22, next_comp);
    wr_reg(4'hC, 8'hFF);
    rd_chk(4'hC, 8'h00);
    zcap <= 8'hC3;
    dcap <= 8'h99;
    pulse(8'hA0);
    rd_chk(4'h1, 8'h00);
    rd_chk(4'h3, 8'h33);
    wr_reg(4'h6, 8'h00);
    $display("test clock_off finished");
  endtask
  task automatic t_clock_on();
    clr();
    wr_reg(4'h8, 8'h44);
    repeat (3) @(posedge clk);
    chk("clk_en", 8'h01, {7'h00, clk_en});
    chk("cnt_rst", 8'h00, {7'h00, cnt_rst});
    chk("xfer", 8'h01, 8'(xfer_seen));
    rd_chk(4'h7, 8'h80);
    wr_reg(4'h7, 8'h7F);
    rd_chk(4'h7, 8'h00);
    wr_reg(4'h7, 8'h7F);
    rd_chk(4'h7, 8'h00);
    clr();
    wr_reg(4'h7, 8'hFF);
    repeat (3) @(posedge clk);
    chk("xfer", 8'h01, 8'(xfer_seen));
    chk("cnt_pulse", 8'h01, 8'(rst_seen));
    rd_chk(4'h7, 8'h80);
    wr_reg(4'h7, 8'h7F);
    $display("test clock_on finished");
  endtask
  task automatic t_auto();
    wr_reg(4'h4, 8'h3C);
    wr_reg(4'h6, 8'h04);
    wr_reg(4'h8, 8'h45);
    zcap <= 8'hC8;
    pulse(8'h80);
    zcap <= 8'h10;
    pulse(8'h80);
    chk("irq", 8'h04, irq);
    rd_chk(4'h1, 8'h10);
    rd_chk(4'h2, AUTO_EXP);
    wr_reg(4'h8, 8'h44);
    wr_reg(4'h2, 8'h00);
    zcap <= 8'h20;
    pulse(8'h80);
    rd_chk(4'h0, 8'h10);
    rd_chk(4'h1, 8'h20);
    rd_chk(4'h2, AUTO_EXP);
    chk("next", AUTO_EXP, next_comp);
    wr_reg(4'h7, 8'h00);
    $display("test auto finished");
  endtask
  task automatic t_irq();
    logic [7:0] ev [5] = '{8'h08, 8'h40, 8'h80, 8'h02, 8'h04};
    logic [7:0] ex [5] = '{8'h08, 8'h01, 8'h04, 8'h80, 8'h10};
    wr_reg(4'h6, 8'hFF);
    for (int i = 0; i < 5; i++) begin
      pulse(ev[i]);
      chk("irq", ex[i], irq);
      wr_reg(4'h7, 8'h00);
    end
    wr_reg(4'h8, 8'h4C);
    pulse(8'h04);
    chk("irq", 8'h00, irq);
    wr_reg(4'h7, 8'h00);
    wr_reg(4'h8, 8'h44);
    dcap <= 8'h77;
    pulse(8'h30);
    chk("irq", 8'h00, irq);
    rd_chk(4'h3, 8'h33);
    wr_reg(4'h7, 8'h00);
    wr_reg(4'h9, 8'h30);
    pulse(8'h30);
    chk("irq", 8'h02, irq);
    rd_chk(4'h3, 8'h77);
    wr_reg(4'h7, 8'h00);
    wr_reg(4'h9, 8'h00);
    $display("test irq finished");
  endtask
  task automatic t_speed();
    spd_sel <= 2'b01;
    step <= 16'hA55A;
    pulse(8'h01);
    rd_chk(4'h1, 8'hA5);
    step <= 16'h1234;
    pulse(8'h01);
    rd_chk(4'h1, 8'hA5);
    rd_chk(4'h0, 8'h5A);
    pulse(8'h01);
    rd_chk(4'h0, 8'h34);
    rd_chk(4'h1, 8'h12);
    wr_reg(4'h6, 8'h40);
    clr();
    repeat (3) @(posedge clk);
    chk("spd_err", 8'h00, 8'(spd_seen > 0));
    wr_reg(4'h3, 8'h12);
    repeat (3) @(posedge clk);
    chk("spd_err", 8'h01, 8'(spd_seen > 0));
    wr_reg(4'h6, 8'h00);
    wr_reg(4'h7, 8'h00);
    spd_sel <= 2'b00;
    $display("test speed finished");
  endtask
  task automatic t_switched();
    wr_reg(4'h8, 8'h40);
    wr_reg(4'h5, 8'h35);
    wr_reg(4'h7, 8'h9F);
    wr_reg(4'h7, 8'hDF);
    rd_chk(4'h7, 8'h40);
    clr();
    pulse(8'h40);
    repeat (2) @(posedge clk);
    chk("presc", 8'h06, {4'h0, presc});
    chk("shift_r", 8'h01, 8'(shr_seen));
    wr_reg(4'h7, 8'h9F);
    wr_reg(4'h7, 8'hBF);
    clr();
    pulse(8'h40);
    repeat (2) @(posedge clk);
    chk("presc", 8'h05, {4'h0, presc});
    chk("shift_l", 8'h01, 8'(shl_seen));
    rd_chk(4'h5, 8'h35);
    $display("test switched finished");
  endtask
  task automatic t_outputs();
    wr_reg(4'h8, 8'hC0);
    repeat (2) @(posedge clk);
    chk("drive", 8'h03, {6'h00, drive_en, z_run});
    wr_reg(4'h8, 8'h40);
    repeat (2) @(posedge clk);
    chk("drive", 8'h00, {6'h00, drive_en, z_run});
    z_keep <= 1'b1;
    repeat (2) @(posedge clk);
    chk("drive", 8'h01, {6'h00, drive_en, z_run});
    wr_reg(4'h8, 8'h00);
    repeat (2) @(posedge clk);
    chk("drive", 8'h00, {6'h00, drive_en, z_run});
    $display("test outputs finished");
  endtask
  initial begin
    rstn = 1'b0;
    bus = '0;
    evt = '0;
    zcap = 8'h00;
    dcap = 8'h00;
    step = 16'h0000;
    spd_sel = 2'b00;
    pwm_rate = 1'b1;
    z_keep = 1'b0;
    clr();
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_clock_off();
    t_clock_on();
    t_auto();
    t_irq();
    t_speed();
    t_switched();
    t_outputs();
    tally_and_finish();
  end
  // Whole run takes well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
endmodule
bind mc_capture_irq_regs mc_capture_irq_regs_checker u_chk (.*);
`default_nettype wire
